// File: io_select_params.svh
// constants for input activity and source selection
`ifndef IO_SELECT_PARAMS_SVH
`define IO_SELECT_PARAMS_SVH

// register offsets
`define REG_IF_CFG        8'h0F
`define REG_SYNC_CFG      8'h10
`define REG_COAST_CFG     8'h11
`define REG_DETECT_STAT   8'h15
`define REG_SOURCE_STAT   8'h16
`define REG_KEY_PORT      8'h1B

// reset values
`define RST_IF_CFG        8'h00
`define RST_SYNC_CFG      8'h00
`define RST_COAST_CFG     8'h08
`define RST_KEY_PORT      8'h00

// field positions in 0FH
`define IF_PRIO_BIT       1
`define IF_OVR_BIT        2
// field positions in 10H
`define FS_SEL_BIT        0
`define FS_OVR_BIT        1
`define LS_SEL_BIT        3
`define LS_OVR_BIT        4
// field position in 11H
`define COAST_EN_BIT      3
// field position in 1BH
`define KEY_TRI_BIT       7

// detect bit positions in 15H
`define DET_LINE_BIT      7
`define DET_GREEN_BIT     6
`define DET_FRAME_BIT     5
`define DET_DCLK_BIT      4
`define DET_PATH_BIT      3
// bit positions in 16H
`define SRC_LINE_BIT      7
`define SRC_LPOL_BIT      6
`define SRC_FRAME_BIT     5
`define SRC_FPOL_BIT      4
`define SRC_CPOL_BIT      3
`define SRC_KEY_BIT       2

// index of each watched input in the detect vector
`define IDX_DCLK          0
`define IDX_FRAME         1
`define IDX_GREEN         2
`define IDX_LINE          3
`define NUM_WATCH         4

// activity window: no edge for this long means idle
`define CLK_PERIOD_NS     4
`define ACT_WINDOW_NS     100000
`define ACT_WINDOW_CYC    (`ACT_WINDOW_NS / `CLK_PERIOD_NS)
`define ACT_CNT_W         16
`define DUTY_W            12

`endif

// File: io_select_pkg.sv
// types for input activity and source selection
package io_select_pkg;

   // which input path is active; seek holds last choice
   typedef enum logic [2:0] {
      PATH_SEEK    = 3'h1,
      PATH_ANALOG  = 3'h2,
      PATH_DIGITAL = 3'h4
   } path_st_t;

   // state of one activity and polarity watcher
   typedef struct packed {
      logic                 sync1;
      logic                 sync2;
      logic                 prev;
      logic [15:0]          cnt;
      logic                 active;
      logic signed [11:0]   duty;
   } act_st_t;

   // software-visible configuration
   typedef struct packed {
      logic [7:0] if_cfg;
      logic [7:0] sync_cfg;
      logic [7:0] coast_cfg;
      logic [7:0] key_port;
   } cfg_t;

   // routed sync outputs
   typedef struct packed {
      logic pll_line;
      logic out_line;
      logic out_frame;
   } route_t;

   // key memory pin drive
   typedef struct packed {
      logic data_oe;
      logic clock_oe;
      logic data_in;
   } key_pins_t;

   // whole state of the selection block
   typedef struct packed {
      cfg_t       cfg;
      path_st_t   path;
      logic       path_flag;
      logic       line_flag;
      logic       frame_flag;
      logic [7:0] rdata;
      route_t     route;
      logic       kd_s1;
      key_pins_t  key;
   } sel_st_t;

endpackage

// File: activity_detect.sv
// activity and polarity watcher for one sampled input
`include "io_select_params.svh"

module activity_detect #(
   parameter logic [`ACT_CNT_W-1:0] WINDOW_CYC = `ACT_CNT_W'(`ACT_WINDOW_CYC)
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic ce_i,
   // watched input, asynchronous
   input  wire logic pin_i,
   // results
   output logic      active_o,
   output logic      pos_pol_o,
   output logic      level_o
);

   localparam logic signed [`DUTY_W-1:0] DUTY_MAX = {1'b0, {(`DUTY_W-1){1'b1}}};
   localparam logic signed [`DUTY_W-1:0] DUTY_MIN = {1'b1, {(`DUTY_W-1){1'b0}}};

   io_select_pkg::act_st_t s;
   io_select_pkg::act_st_t next_s;

   always_comb begin
      next_s = s;
      next_s.sync1 = pin_i;
      next_s.sync2 = s.sync1;
      next_s.prev  = s.sync2;
      // a pin stuck high or low never restarts the window
      if (s.sync2 != s.prev) begin
         next_s.cnt    = '0;
         next_s.active = 1'b1;
      end else if (s.cnt >= WINDOW_CYC - `ACT_CNT_W'(1)) begin
         next_s.active = 1'b0;
      end else begin
         next_s.cnt = s.cnt + `ACT_CNT_W'(1);
      end
      // time spent high against time spent low
      if (s.sync2 && s.duty != DUTY_MAX) begin
         next_s.duty = s.duty + `DUTY_W'(1);
      end else if (!s.sync2 && s.duty != DUTY_MIN) begin
         next_s.duty = s.duty - `DUTY_W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= '0;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign active_o  = s.active;
   // mostly low means short high pulses
   assign pos_pol_o = s.duty[`DUTY_W-1];
   assign level_o   = s.sync2;

endmodule // activity_detect

// File: input_activity_source_select.sv
// input activity detection and sync source selection
//
// How it works
// - detect bit 4 follows activity on the digital link clock
// - analog detected when any of line, green or frame activity
// - only digital gives flag 1, only analog 0, none enters seek
// - both detected without override: flag copies priority bit
// - interface override forces flag to the priority bit
// - flag 0 routes analog signals, 1 routes digital signals
// - line flag 0 for pin only, 1 for green only, else select bit
// - line override forces line flag to its select bit
// - pll takes line pin on flag 0, green sync on flag 1
// - status bit 6 gives line sync polarity, 1 active high
// - frame flag follows frame detect, or select bit under override
// - frame sync from pin on flag 0, separator on flag 1
// - status bit 4 gives frame output polarity, 1 active low
// - status bit 3 coast polarity, valid only with internal coast
// - status bit 2 set when keys were found in key memory
// - key port bit 7 releases key memory data and clock lines
// - detect bit 7 line activity, stuck pin is not activity
// - detect bit 6 green embedded sync activity
// - detect bit 5 frame activity, stuck pin is not activity
`include "io_select_params.svh"

module input_activity_source_select #(
   parameter logic [`ACT_CNT_W-1:0] ACT_WINDOW_CYC = `ACT_CNT_W'(`ACT_WINDOW_CYC)
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       ce_i,
   // register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // watched pins, asynchronous
   input  wire logic       line_sync_i,
   input  wire logic       green_embedded_sync_i,
   input  wire logic       frame_sync_i,
   input  wire logic       link_clock_i,
   // same-clock sources
   input  wire logic       sep_frame_sync_i,
   input  wire logic       dig_line_sync_i,
   input  wire logic       dig_frame_sync_i,
   input  wire logic       key_found_i,
   // selection results
   output logic            input_path_flag_o,
   output logic            seek_o,
   output logic            pll_line_sync_o,
   output logic            out_line_sync_o,
   output logic            out_frame_sync_o,
   // internal key reader drive
   input  wire logic       kr_data_low_i,
   input  wire logic       kr_clock_low_i,
   output logic            kr_data_o,
   // key memory pins, open drain
   input  wire logic       key_mem_data_line_i,
   output logic            key_mem_data_line_o,
   output logic            key_mem_data_line_oe_o,
   output logic            key_mem_clock_line_o,
   output logic            key_mem_clock_line_oe_o
);

   io_select_pkg::sel_st_t s;
   io_select_pkg::sel_st_t next_s;

   logic [`NUM_WATCH-1:0] det;
   logic [`NUM_WATCH-1:0] pol;
   logic [`NUM_WATCH-1:0] lvl;

   logic       an_det;
   logic       dg_det;
   logic       prio;
   logic       coast_pol;
   logic       frame_low;
   logic       pll_line;
   logic       ana_frame;
   logic [7:0] det_stat;
   logic [7:0] src_stat;

   // one watcher per pin
   activity_detect #(
      .WINDOW_CYC (ACT_WINDOW_CYC)
   ) u_watch_dclk (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .ce_i      (ce_i),
      .pin_i     (link_clock_i),
      .active_o  (det[`IDX_DCLK]),
      .pos_pol_o (pol[`IDX_DCLK]),
      .level_o   (lvl[`IDX_DCLK])
   );

   activity_detect #(
      .WINDOW_CYC (ACT_WINDOW_CYC)
   ) u_watch_frame (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .ce_i      (ce_i),
      .pin_i     (frame_sync_i),
      .active_o  (det[`IDX_FRAME]),
      .pos_pol_o (pol[`IDX_FRAME]),
      .level_o   (lvl[`IDX_FRAME])
   );

   activity_detect #(
      .WINDOW_CYC (ACT_WINDOW_CYC)
   ) u_watch_green (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .ce_i      (ce_i),
      .pin_i     (green_embedded_sync_i),
      .active_o  (det[`IDX_GREEN]),
      .pos_pol_o (pol[`IDX_GREEN]),
      .level_o   (lvl[`IDX_GREEN])
   );

   activity_detect #(
      .WINDOW_CYC (ACT_WINDOW_CYC)
   ) u_watch_line (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .ce_i      (ce_i),
      .pin_i     (line_sync_i),
      .active_o  (det[`IDX_LINE]),
      .pos_pol_o (pol[`IDX_LINE]),
      .level_o   (lvl[`IDX_LINE])
   );

   // register read mux
   function automatic logic [7:0] read_reg(
      input logic [7:0]         addr,
      input io_select_pkg::cfg_t cfg,
      input logic [7:0]         dstat,
      input logic [7:0]         sstat
   );
      case (addr)
         `REG_IF_CFG:      read_reg = cfg.if_cfg;
         `REG_SYNC_CFG:    read_reg = cfg.sync_cfg;
         `REG_COAST_CFG:   read_reg = cfg.coast_cfg;
         `REG_DETECT_STAT: read_reg = dstat;
         `REG_SOURCE_STAT: read_reg = sstat;
         `REG_KEY_PORT:    read_reg = cfg.key_port;
         default:          read_reg = 8'h00;
      endcase
   endfunction

   always_comb begin
      an_det = det[`IDX_LINE] | det[`IDX_GREEN] | det[`IDX_FRAME];
      dg_det = det[`IDX_DCLK];
      prio   = s.cfg.if_cfg[`IF_PRIO_BIT];

      // frame output polarity: separator output is active high
      frame_low = s.frame_flag ? 1'b0 : ~pol[`IDX_FRAME];
      // coast follows the frame pulse; zero while coast disabled
      coast_pol = s.cfg.coast_cfg[`COAST_EN_BIT] & ~frame_low;

      det_stat = 8'h00;
      det_stat[`DET_LINE_BIT]  = det[`IDX_LINE];
      det_stat[`DET_GREEN_BIT] = det[`IDX_GREEN];
      det_stat[`DET_FRAME_BIT] = det[`IDX_FRAME];
      det_stat[`DET_DCLK_BIT]  = dg_det;
      det_stat[`DET_PATH_BIT]  = s.path_flag;

      src_stat = 8'h00;
      src_stat[`SRC_LINE_BIT]  = s.line_flag;
      src_stat[`SRC_LPOL_BIT]  = pol[`IDX_LINE];
      src_stat[`SRC_FRAME_BIT] = s.frame_flag;
      src_stat[`SRC_FPOL_BIT]  = frame_low;
      src_stat[`SRC_CPOL_BIT]  = coast_pol;
      src_stat[`SRC_KEY_BIT]   = key_found_i;

      pll_line  = s.line_flag ? lvl[`IDX_GREEN] : lvl[`IDX_LINE];
      ana_frame = s.frame_flag ? sep_frame_sync_i : lvl[`IDX_FRAME];
   end

   always_comb begin
      next_s = s;

      // software writes; status offsets are not writable
      if (reg_wr_i) begin
         case (reg_addr_i)
            `REG_IF_CFG:    next_s.cfg.if_cfg    = reg_wdata_i;
            `REG_SYNC_CFG:  next_s.cfg.sync_cfg  = reg_wdata_i;
            `REG_COAST_CFG: next_s.cfg.coast_cfg = reg_wdata_i;
            `REG_KEY_PORT:  next_s.cfg.key_port  = reg_wdata_i;
            default:        next_s.cfg = s.cfg;
         endcase
      end
      if (reg_rd_i) begin
         next_s.rdata = read_reg(reg_addr_i, s.cfg, det_stat, src_stat);
      end

      // interface choice
      if (s.cfg.if_cfg[`IF_OVR_BIT]) begin
         next_s.path = prio ? io_select_pkg::PATH_DIGITAL : io_select_pkg::PATH_ANALOG;
      end else begin
         case ({an_det, dg_det})
            2'h0: next_s.path = io_select_pkg::PATH_SEEK;
            2'h1: next_s.path = io_select_pkg::PATH_DIGITAL;
            2'h2: next_s.path = io_select_pkg::PATH_ANALOG;
            2'h3: next_s.path = prio ? io_select_pkg::PATH_DIGITAL
                                     : io_select_pkg::PATH_ANALOG;
            default: next_s.path = io_select_pkg::PATH_SEEK;
         endcase
      end
      // seek keeps the last decided interface
      case (next_s.path)
         io_select_pkg::PATH_DIGITAL: next_s.path_flag = 1'b1;
         io_select_pkg::PATH_ANALOG:  next_s.path_flag = 1'b0;
         default:                     next_s.path_flag = s.path_flag;
      endcase

      // line sync source
      if (s.cfg.sync_cfg[`LS_OVR_BIT] || det[`IDX_LINE] == det[`IDX_GREEN]) begin
         next_s.line_flag = s.cfg.sync_cfg[`LS_SEL_BIT];
      end else begin
         next_s.line_flag = det[`IDX_GREEN];
      end

      // frame sync source
      if (s.cfg.sync_cfg[`FS_OVR_BIT]) begin
         next_s.frame_flag = s.cfg.sync_cfg[`FS_SEL_BIT];
      end else begin
         next_s.frame_flag = det[`IDX_FRAME];
      end

      // routed sync
      next_s.route.pll_line  = pll_line;
      next_s.route.out_line  = s.path_flag ? dig_line_sync_i : pll_line;
      next_s.route.out_frame = s.path_flag ? dig_frame_sync_i : ana_frame;

      // key memory port, released when three-stated
      next_s.kd_s1        = key_mem_data_line_i;
      next_s.key.data_in  = s.kd_s1;
      next_s.key.data_oe  = ~s.cfg.key_port[`KEY_TRI_BIT] & kr_data_low_i;
      next_s.key.clock_oe = ~s.cfg.key_port[`KEY_TRI_BIT] & kr_clock_low_i;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s                <= '0;
         s.cfg.if_cfg     <= `RST_IF_CFG;
         s.cfg.sync_cfg   <= `RST_SYNC_CFG;
         s.cfg.coast_cfg  <= `RST_COAST_CFG;
         s.cfg.key_port   <= `RST_KEY_PORT;
         s.path           <= io_select_pkg::PATH_SEEK;
         s.key.data_in    <= 1'b1;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign reg_rdata_o             = s.rdata;
   assign input_path_flag_o       = s.path_flag;
   assign seek_o                  = s.path == io_select_pkg::PATH_SEEK;
   assign pll_line_sync_o         = s.route.pll_line;
   assign out_line_sync_o         = s.route.out_line;
   assign out_frame_sync_o        = s.route.out_frame;
   assign kr_data_o               = s.key.data_in;
   assign key_mem_data_line_o     = 1'b0;
   assign key_mem_data_line_oe_o  = s.key.data_oe;
   assign key_mem_clock_line_o    = 1'b0;
   assign key_mem_clock_line_oe_o = s.key.clock_oe;

endmodule // input_activity_source_select

// File: io_sel_monitor.sv
// port assertions for the selection block
module io_sel_monitor (
   // clock and reset
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic       ce_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // results
   input wire logic       input_path_flag_o,
   input wire logic       seek_o,
   input wire logic       key_mem_data_line_oe_o,
   input wire logic       key_mem_clock_line_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] if_cfg;
   logic [7:0] key_cfg;
   logic       wr;
   logic       rd;
   assign wr = reg_wr_i && ce_i;
   assign rd = reg_rd_i && ce_i;
   // shadows of written config
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         if_cfg  <= 8'h00;
         key_cfg <= 8'h00;
      end else begin
         if (wr && reg_addr_i == 8'h0F) if_cfg <= reg_wdata_i;
         if (wr && reg_addr_i == 8'h1B) key_cfg <= reg_wdata_i;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence rd_at(logic [7:0] a);
      rd && reg_addr_i == a;
   endsequence
   a_if_cfg_readback:
   assert property (rd_at(8'h0F) |=> reg_rdata_o[2:1] == $past(if_cfg[2:1])) else $error("config readback");
   a_key_port_readback:
   assert property (rd_at(8'h1B) |=> reg_rdata_o[7] == $past(key_cfg[7])) else $error("key port readback");
   a_detect_spare_zero:
   assert property (rd_at(8'h15) |=> reg_rdata_o[2:0] == 3'h0) else $error("spare detect bits set");
   a_path_in_status:
   assert property (rd_at(8'h15) |=> reg_rdata_o[3] == $past(input_path_flag_o)) else $error("path bit");
   a_override_path:
   assert property ($past(if_cfg[2]) |-> input_path_flag_o == $past(if_cfg[1])) else $error("override path");
   a_override_no_seek:
   assert property ($past(if_cfg[2]) |-> !seek_o) else $error("seek under override");
   a_seek_holds_path:
   assert property (seek_o && $past(seek_o) && !$past(if_cfg[2]) |-> $stable(input_path_flag_o))
      else $error("path moved in seek");
   a_key_lines_released:
   assert property (key_cfg[7] && $past(key_cfg[7]) |-> !key_mem_data_line_oe_o && !key_mem_clock_line_oe_o)
      else $error("key lines driven");
   a_rdata_holds:
   assert property (!$past(rd) |-> $stable(reg_rdata_o)) else $error("read data moved");
endmodule // io_sel_monitor

// File: video_source_model.sv
// video source model driving the watched sync pins
module video_source_model (
   // clock
   input  wire logic       clk_i,
   // toggle enable and idle level: line green frame link
   input  wire logic [3:0] act_i,
   input  wire logic [3:0] lvl_i,
   input  wire logic       narrow_i,
   // pins
   output logic            line_sync_o,
   output logic            green_sync_o,
   output logic            frame_sync_o,
   output logic            link_clock_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt = 3'h0;
   always @(negedge clk_i) begin
      cnt <= cnt + 3'h1;
   end
   // narrow: high one slot in eight, else low one slot
   assign line_sync_o  = act_i[3] ? (narrow_i ? cnt == 3'h0 : cnt != 3'h0) : lvl_i[3];
   assign green_sync_o = act_i[2] ? cnt[2] : lvl_i[2];
   assign frame_sync_o = act_i[1] ? cnt[2] : lvl_i[1];
   assign link_clock_o = act_i[0] ? cnt[0] : lvl_i[0];
endmodule // video_source_model

// File: input_activity_source_select_tb_top.sv
// self-checking bench for input activity and source selection
module input_activity_source_select_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WIN = 64;
   logic       clk_i = 1'b0;
   logic       rst_b_i = 1'b0;
   logic       ce_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic       reg_wr_i = 1'b0;
   logic       reg_rd_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [7:0] reg_rdata_o;
   logic       line_sync_i;
   logic       green_embedded_sync_i;
   logic       frame_sync_i;
   logic       link_clock_i;
   logic       sep_frame_sync_i = 1'b0;
   logic       dig_line_sync_i = 1'b0;
   logic       dig_frame_sync_i = 1'b0;
   logic       key_found_i = 1'b0;
   logic       kr_data_low_i = 1'b0;
   logic       kr_clock_low_i = 1'b0;
   logic       input_path_flag_o;
   logic       seek_o;
   logic       pll_line_sync_o;
   logic       out_line_sync_o;
   logic       out_frame_sync_o;
   logic       kr_data_o;
   logic       key_mem_data_line_i;
   logic       key_mem_data_line_oe_o;
   logic       key_mem_clock_line_oe_o;
   logic [3:0] act = 4'h0;
   logic [3:0] lvl = 4'h0;
   logic       narrow = 1'b0;
   int         n_fail = 0;
   int         tests_run = 0;

   always #2 clk_i = ~clk_i;
   assign key_mem_data_line_i = !key_mem_data_line_oe_o;

   input_activity_source_select #(.ACT_WINDOW_CYC(16'h0040)) dut (
      .clk_i, .rst_b_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
      .line_sync_i, .green_embedded_sync_i, .frame_sync_i, .link_clock_i, .sep_frame_sync_i,
      .dig_line_sync_i, .dig_frame_sync_i, .key_found_i, .input_path_flag_o, .seek_o, .pll_line_sync_o,
      .out_line_sync_o, .out_frame_sync_o, .kr_data_low_i, .kr_clock_low_i, .kr_data_o,
      .key_mem_data_line_i, .key_mem_data_line_o(), .key_mem_data_line_oe_o, .key_mem_clock_line_o(),
      .key_mem_clock_line_oe_o);

   video_source_model src (.clk_i, .act_i(act), .lvl_i(lvl), .narrow_i(narrow), .line_sync_o(line_sync_i),
      .green_sync_o(green_embedded_sync_i), .frame_sync_o(frame_sync_i), .link_clock_o(link_clock_i));

   task automatic finish_test;
      if (n_fail == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      wt(1);
      reg_wr_i = 1'b0;
      wt(1);
   endtask

   task automatic rck(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      wt(1);
      reg_rd_i = 1'b0;
      chk(reg_rdata_o & m, e);
      wt(1);
   endtask

   task automatic t_reset;
      rck(8'h0F, 8'hFF, 8'h00);
      rck(8'h10, 8'hFF, 8'h00);
      rck(8'h11, 8'hFF, 8'h08);
      rck(8'h1B, 8'hFF, 8'h00);
      rck(8'h20, 8'hFF, 8'h00);
      rck(8'h15, 8'hFF, 8'h00);
      rck(8'h16, 8'h04, 8'h00);
      chk(8'(seek_o), 8'h01);
   endtask

   task automatic t_path;
      act = 4'h1;
      dig_line_sync_i = 1'b1;
      wt(20);
      rck(8'h15, 8'hF8, 8'h18);
      chk(8'({seek_o, out_line_sync_o}), 8'h01);
      act = 4'h9;
      wt(20);
      rck(8'h15, 8'hF8, 8'h90);
      wr(8'h0F, 8'h02);
      wt(4);
      rck(8'h15, 8'hF8, 8'h98);
      act = 4'h0;
      lvl = 4'hF;
      wt(2 * WIN + 20);
      rck(8'h15, 8'hF8, 8'h08);
      chk(8'(seek_o), 8'h01);
      wr(8'h0F, 8'h04);
      wt(4);
      chk(8'({seek_o, input_path_flag_o}), 8'h00);
   endtask

   task automatic t_source;
      // let the edges from dropping the idle levels age out first
      act = 4'h0;
      lvl = 4'h0;
      wt(2 * WIN + 20);
      act = 4'h4;
      wt(20);
      rck(8'h15, 8'hE0, 8'h40);
      rck(8'h16, 8'hA0, 8'h80);
      act = 4'hA;
      wt(2 * WIN + 20);
      rck(8'h15, 8'hE0, 8'hA0);
      rck(8'h16, 8'hA0, 8'h20);
      act = 4'h0;
      lvl = 4'h4;
      sep_frame_sync_i = 1'b1;
      wr(8'h10, 8'h10);
      wt(6);
      chk(8'(pll_line_sync_o), 8'h00);
      wr(8'h10, 8'h1B);
      wt(6);
      chk(8'({pll_line_sync_o, out_line_sync_o, out_frame_sync_o}), 8'h07);
      rck(8'h16, 8'hB8, 8'hA8);
      wr(8'h11, 8'h00);
      wt(2);
      rck(8'h16, 8'h08, 8'h00);
      wr(8'h10, 8'h12);
      wt(6);
      chk(8'({pll_line_sync_o, out_frame_sync_o}), 8'h00);
      wr(8'h0F, 8'h06);
      wt(6);
      chk(8'({out_line_sync_o, out_frame_sync_o}), 8'h02);
   endtask

   task automatic t_polarity;
      act = 4'h8;
      narrow = 1'b1;
      wt(4000);
      rck(8'h16, 8'h40, 8'h40);
      narrow = 1'b0;
      wt(4000);
      rck(8'h16, 8'h40, 8'h00);
   endtask

   task automatic t_key;
      // a write while the clock enable is low must not land
      ce_i = 1'b0;
      wr(8'h0F, 8'h04);
      ce_i = 1'b1;
      rck(8'h0F, 8'hFF, 8'h06);
      chk(8'(input_path_flag_o), 8'h01);
      key_found_i = 1'b1;
      kr_data_low_i = 1'b1;
      kr_clock_low_i = 1'b1;
      wt(6);
      rck(8'h16, 8'h04, 8'h04);
      chk(8'({key_mem_data_line_oe_o, key_mem_clock_line_oe_o, kr_data_o}), 8'h06);
      wr(8'h1B, 8'h80);
      wt(6);
      chk(8'({key_mem_data_line_oe_o, key_mem_clock_line_oe_o, kr_data_o}), 8'h01);
      rck(8'h1B, 8'h80, 8'h80);
      wr(8'h16, 8'h00);
      wr(8'h15, 8'hFF);
      rck(8'h16, 8'h04, 8'h04);
      rck(8'h15, 8'h07, 8'h00);
   endtask

   initial begin
      wt(4);
      rst_b_i = 1'b1;
      wt(1);
      t_reset();
      t_path();
      t_source();
      t_polarity();
      t_key();
      finish_test();
   end

   initial begin
      repeat (40000) @(posedge clk_i);
      n_fail++;
      finish_test();
   end
endmodule // input_activity_source_select_tb_top

bind input_activity_source_select io_sel_monitor u_mon (
   .clk_i, .rst_b_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
   .input_path_flag_o, .seek_o, .key_mem_data_line_oe_o, .key_mem_clock_line_oe_o);
